// ==== flash_map_pkg.sv ====
// constants, region and field codes for the flash global-address decoder
// assumes 23-bit global addresses from a bus master on the same clock
package flash_map_pkg;
    localparam int ADDR_W = 23;
    localparam int OFFS_W = 18;
    localparam logic [22:0] PFLASH_LO = 23'h7C0000;
    localparam logic [22:0] PFLASH_HI = 23'h7FFFFF;
    localparam logic [22:0] LOWER_BASE = 23'h7F8000;
    localparam logic [22:0] CFG_KEY_LO = 23'h7FFF00;
    localparam logic [22:0] CFG_KEY_HI = 23'h7FFF07;
    localparam logic [22:0] CFG_RSV_LO = 23'h7FFF08;
    localparam logic [22:0] CFG_RSV_HI = 23'h7FFF0B;
    localparam logic [22:0] CFG_PPROT = 23'h7FFF0C;
    localparam logic [22:0] CFG_DPROT = 23'h7FFF0D;
    localparam logic [22:0] CFG_OPT = 23'h7FFF0E;
    localparam logic [22:0] CFG_SEC = 23'h7FFF0F;
    localparam logic [22:0] PINFO_ID_LO = 23'h400000;
    localparam logic [22:0] PINFO_ID_HI = 23'h400007;
    localparam logic [22:0] PINFO_VER_LO = 23'h4000E8;
    localparam logic [22:0] PINFO_VER_HI = 23'h4000E9;
    localparam logic [22:0] PINFO_ONCE_LO = 23'h400100;
    localparam logic [22:0] PINFO_ONCE_HI = 23'h40013F;
    localparam logic [22:0] DFLASH_LO = 23'h100000;
    localparam logic [22:0] DFLASH_HI = 23'h101FFF;
    localparam logic [22:0] DINFO_LO = 23'h120000;
    localparam logic [22:0] DINFO_HI = 23'h12007F;
    localparam logic [22:0] SRAM_LO = 23'h123D00;
    localparam logic [22:0] SRAM_HI = 23'h123FFF;
    // protection byte fields
    localparam int PROT_OPEN = 7;
    localparam int PROT_HDIS = 5;
    localparam int PROT_HS = 3;
    localparam int PROT_LDIS = 2;
    localparam int PROT_LS = 0;
    // smallest protected region size in bytes, doubled per size step
    localparam logic [22:0] PROT_UNIT = 23'h000800;
    localparam logic [7:0] PROT_RESET = 8'hFF;
    typedef enum logic [2:0] {REG_NONE, REG_PFLASH, REG_PINFO, REG_DFLASH, REG_DINFO,
        REG_SRAM} region_e;
    typedef enum logic [2:0] {CFG_NONE, CFG_KEY, CFG_RSV, CFG_PROT_P, CFG_PROT_D, CFG_OPTION,
        CFG_SECURE} cfg_e;
endpackage

// ==== flash_prot_if.sv ====
// carries a program address and protection byte to the region checker
// assumes the decoder drives address and byte, the checker answers combinationally
`timescale 1ns/1ps
interface flash_prot_if;
    logic [22:0] addr;
    logic [7:0] prot;
    logic in_lower;
    logic in_higher;
    logic blocked;
    modport dec (output addr, output prot, input in_lower, input in_higher, input blocked);
    modport chk (input addr, input prot, output in_lower, output in_higher, output blocked);
endinterface // flash_prot_if

// ==== flash_prot_check.sv ====
// program-array protection region checker
// assumes addr already lies inside the program array
`timescale 1ns/1ps
module flash_prot_check (
    flash_prot_if.chk pif
);
    logic [22:0] low_size;
    logic [22:0] high_size;
    logic low_act;
    logic high_act;

    always_comb
    begin
        low_size = flash_map_pkg::PROT_UNIT << pif.prot[flash_map_pkg::PROT_LS +: 2];
        high_size = flash_map_pkg::PROT_UNIT << pif.prot[flash_map_pkg::PROT_HS +: 2];
        pif.in_lower = (pif.addr >= flash_map_pkg::LOWER_BASE)
            && (pif.addr < 23'(flash_map_pkg::LOWER_BASE + low_size));
        pif.in_higher = pif.addr > 23'(flash_map_pkg::PFLASH_HI - high_size);
        low_act = pif.in_lower && !pif.prot[flash_map_pkg::PROT_LDIS];
        high_act = pif.in_higher && !pif.prot[flash_map_pkg::PROT_HDIS];
        // open mode protects the listed regions, closed mode the remaining one
        if (pif.prot[flash_map_pkg::PROT_OPEN])
        begin
            pif.blocked = low_act || high_act;
        end
        else
        begin
            pif.blocked = !(low_act || high_act);
        end
    end
endmodule // flash_prot_check

// ==== flash_memory_map_decode.sv ====
// global-address decoder for the flash module's arrays, rows and scratch RAM
// assumes request strobes, address and visibility bits come from same-clock logic
`timescale 1ns/1ps
module flash_memory_map_decode (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [22:0] addr_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic pe_i,
    input wire logic [7:0] program_array_protection_i,
    input wire logic program_info_row_visible_i,
    input wire logic data_info_row_visible_i,
    input wire logic scratch_ram_visible_i,
    output flash_map_pkg::region_e region_o,
    output flash_map_pkg::cfg_e cfg_field_o,
    output logic [17:0] offset_o,
    output logic rd_en_o,
    output logic wr_en_o,
    output logic pe_en_o,
    output logic pe_blocked_o,
    output logic unmapped_o
);
    flash_prot_if pif ();
    flash_map_pkg::region_e region_d;
    flash_map_pkg::cfg_e cfg_d;
    logic [17:0] offs_d;
    logic in_pinfo;

    assign pif.addr = addr_i;
    assign pif.prot = program_array_protection_i;

    flash_prot_check u_check (
        .pif(pif)
    );

    function automatic logic in_rng(input logic [22:0] a, input logic [22:0] lo,
        input logic [22:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    always_comb
    begin
        region_d = flash_map_pkg::REG_NONE;
        cfg_d = flash_map_pkg::CFG_NONE;
        offs_d = 18'h00000;
        // only ID, version and once fields are implemented
        in_pinfo = in_rng(addr_i, flash_map_pkg::PINFO_ID_LO, flash_map_pkg::PINFO_ID_HI)
            || in_rng(addr_i, flash_map_pkg::PINFO_VER_LO, flash_map_pkg::PINFO_VER_HI)
            || in_rng(addr_i, flash_map_pkg::PINFO_ONCE_LO, flash_map_pkg::PINFO_ONCE_HI);
        if (in_rng(addr_i, flash_map_pkg::PFLASH_LO, flash_map_pkg::PFLASH_HI))
        begin
            region_d = flash_map_pkg::REG_PFLASH;
            offs_d = addr_i[17:0];
        end
        else if (in_pinfo && program_info_row_visible_i)
        begin
            region_d = flash_map_pkg::REG_PINFO;
            offs_d = {9'h000, addr_i[8:0]};
        end
        // data array, reserved tail stays unmapped
        else if (in_rng(addr_i, flash_map_pkg::DFLASH_LO, flash_map_pkg::DFLASH_HI))
        begin
            region_d = flash_map_pkg::REG_DFLASH;
            offs_d = {5'h00, addr_i[12:0]};
        end
        // data row gated by its visibility bit
        else if (in_rng(addr_i, flash_map_pkg::DINFO_LO, flash_map_pkg::DINFO_HI)
            && data_info_row_visible_i)
        begin
            region_d = flash_map_pkg::REG_DINFO;
            offs_d = {11'h000, addr_i[6:0]};
        end
        // scratch RAM gated by its visibility bit
        else if (in_rng(addr_i, flash_map_pkg::SRAM_LO, flash_map_pkg::SRAM_HI)
            && scratch_ram_visible_i)
        begin
            region_d = flash_map_pkg::REG_SRAM;
            offs_d = {4'h0, 14'(addr_i[13:0] - flash_map_pkg::SRAM_LO[13:0])};
        end
        // key, reserved, protection, option and security bytes of the configuration field
        if (in_rng(addr_i, flash_map_pkg::CFG_KEY_LO, flash_map_pkg::CFG_KEY_HI))
        begin
            cfg_d = flash_map_pkg::CFG_KEY;
        end
        else if (in_rng(addr_i, flash_map_pkg::CFG_RSV_LO, flash_map_pkg::CFG_RSV_HI))
        begin
            cfg_d = flash_map_pkg::CFG_RSV;
        end
        else if (addr_i == flash_map_pkg::CFG_PPROT)
        begin
            cfg_d = flash_map_pkg::CFG_PROT_P;
        end
        else if (addr_i == flash_map_pkg::CFG_DPROT)
        begin
            cfg_d = flash_map_pkg::CFG_PROT_D;
        end
        else if (addr_i == flash_map_pkg::CFG_OPT)
        begin
            cfg_d = flash_map_pkg::CFG_OPTION;
        end
        else if (addr_i == flash_map_pkg::CFG_SEC)
        begin
            cfg_d = flash_map_pkg::CFG_SECURE;
        end
    end

    // decoded target, registered anew every cycle
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            region_o <= flash_map_pkg::REG_NONE;
            cfg_field_o <= flash_map_pkg::CFG_NONE;
            offset_o <= 18'h00000;
        end
        else
        begin
            region_o <= region_d;
            cfg_field_o <= cfg_d;
            offset_o <= offs_d;
        end
    end

    // access strobes
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            rd_en_o <= 1'b0;
            wr_en_o <= 1'b0;
            unmapped_o <= 1'b0;
        end
        else
        begin
            rd_en_o <= rd_i && (region_d != flash_map_pkg::REG_NONE);
            // writes to unmapped or reserved space are dropped
            wr_en_o <= wr_i && (region_d != flash_map_pkg::REG_NONE)
                && (cfg_d != flash_map_pkg::CFG_RSV);
            unmapped_o <= (rd_i || wr_i) && (region_d == flash_map_pkg::REG_NONE);
        end
    end

    // program and erase permission
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            pe_en_o <= 1'b0;
            pe_blocked_o <= 1'b0;
        end
        else
        begin
            // protected program addresses refuse program and erase
            pe_blocked_o <= pe_i && (region_d == flash_map_pkg::REG_PFLASH) && pif.blocked;
            pe_en_o <= pe_i && (region_d != flash_map_pkg::REG_NONE)
                && !((region_d == flash_map_pkg::REG_PFLASH) && pif.blocked);
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    AST_RD_UNDEF: assert property (rd_i && addr_i == 23'h300000
        |=> unmapped_o && !rd_en_o)
        else $error("unmapped read not flagged");
    AST_WR_DROP: assert property (wr_i && in_rng(addr_i, 23'h102000, 23'h11FFFF)
        |=> !wr_en_o && region_o == flash_map_pkg::REG_NONE)
        else $error("reserved write accepted");
    AST_CFG_RSV_WR: assert property (wr_i && in_rng(addr_i, 23'h7FFF08, 23'h7FFF0B)
        |=> !wr_en_o && !unmapped_o)
        else $error("reserved configuration write accepted");
    AST_PFLASH: assert property ((rd_i || wr_i) && addr_i[22:18] == 5'h1F
        |=> region_o == flash_map_pkg::REG_PFLASH && offset_o == $past(addr_i[17:0]))
        else $error("program array decode wrong");
    AST_LOWER: assert property (pe_i && addr_i == 23'h7F8000
        && program_array_protection_i[7] && !program_array_protection_i[2]
        |=> pe_blocked_o && !pe_en_o)
        else $error("lower region not protected");
    AST_HIGHER: assert property (pe_i && addr_i == 23'h7FFFFF
        && program_array_protection_i[7:5] == 3'b100 |=> pe_blocked_o)
        else $error("higher region not protected");
    AST_CFG_KEY: assert property (rd_i && in_rng(addr_i, 23'h7FFF00, 23'h7FFF07)
        |=> cfg_field_o == flash_map_pkg::CFG_KEY)
        else $error("key bytes misdecoded");
    AST_CFG_SEC: assert property (rd_i && addr_i == 23'h7FFF0F
        |=> cfg_field_o == flash_map_pkg::CFG_SECURE)
        else $error("security byte misdecoded");
    AST_PINFO: assert property (rd_i && addr_i == 23'h4000E8
        |=> (region_o == flash_map_pkg::REG_PINFO) == $past(program_info_row_visible_i))
        else $error("program row visibility wrong");
    AST_PINFO_RSV: assert property (wr_i && addr_i == 23'h400140 |=> !wr_en_o)
        else $error("program row reserved write accepted");
    AST_DFLASH: assert property (rd_i && addr_i == 23'h101FFF
        |=> region_o == flash_map_pkg::REG_DFLASH && offset_o == 18'h01FFF)
        else $error("data array decode wrong");
    AST_DINFO: assert property (wr_i && addr_i == 23'h12007F
        && !data_info_row_visible_i |=> !wr_en_o && unmapped_o)
        else $error("hidden data row written");
    AST_SRAM: assert property (rd_i && addr_i == 23'h123D00
        && scratch_ram_visible_i
        |=> region_o == flash_map_pkg::REG_SRAM && offset_o == 18'h00000)
        else $error("scratch RAM decode wrong");
    AST_SRAM_HIDDEN: assert property ((rd_i || wr_i) && !scratch_ram_visible_i
        && in_rng(addr_i, 23'h123D00, 23'h123FFF)
        |=> unmapped_o && region_o == flash_map_pkg::REG_NONE)
        else $error("hidden scratch RAM decoded");

    COV_PF_WR: cover property (wr_i ##1 wr_en_o && region_o == flash_map_pkg::REG_PFLASH);
    COV_UNMAPPED: cover property ((rd_i || wr_i) ##1 unmapped_o);
    COV_BLOCK: cover property (pe_i ##1 pe_blocked_o);
    COV_SRAM: cover property (rd_i ##1 rd_en_o && region_o == flash_map_pkg::REG_SRAM);
endmodule // flash_memory_map_decode

// ==== bus_master_model.sv ====
// bus master model issuing global-address requests to the flash decoder
// assumes the caller invokes its tasks right after a rising clock edge
`timescale 1ns/1ps
module bus_master_model (
    output logic [22:0] addr_o,
    output logic rd_o,
    output logic wr_o,
    output logic pe_o
);
    initial
    begin
        addr_o = 23'h000000;
        rd_o = 1'b0;
        wr_o = 1'b0;
        pe_o = 1'b0;
    end
    // kind 0 read, 1 write, 2 program/erase
    task automatic drive(input logic [1:0] k, input logic [22:0] a);
        addr_o <= a;
        rd_o <= (k == 2'h0);
        wr_o <= (k == 2'h1);
        pe_o <= (k == 2'h2);
    endtask
    // released bus shows the inverse of its last address, not a held value
    task automatic release_bus();
        addr_o <= ~addr_o;
        rd_o <= 1'b0;
        wr_o <= 1'b0;
        pe_o <= 1'b0;
    endtask
endmodule // bus_master_model

// ==== flash_memory_map_decode_bench.sv ====
// self-checking bench for the flash global-address decoder
// assumes registered answers one edge after the request edge
`timescale 1ns/1ps
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin n_mismatch++; \
    $display("Error %s expected %h seen %h", nm, e, s); end end
module flash_memory_map_decode_bench;
    // rg/cf follow the package enum order; en is {rd, wr, pe, blocked, unmapped}
    typedef struct packed {
        logic [22:0] a;
        logic [1:0] k;
        logic [2:0] v;
        logic [7:0] p;
        logic [2:0] rg;
        logic [2:0] cf;
        logic [4:0] en;
    } row_s;
    logic ref_clk_i;
    logic rst_i;
    logic [2:0] vis;
    logic [7:0] prot;
    logic [22:0] addr;
    logic rd;
    logic wr;
    logic pe;
    flash_map_pkg::region_e region_o;
    flash_map_pkg::cfg_e cfg_field_o;
    logic [17:0] offset_o;
    logic rd_en_o;
    logic wr_en_o;
    logic pe_en_o;
    logic pe_blocked_o;
    logic unmapped_o;
    logic [4:0] strobes;
    int n_mismatch;
    int tests_run;
    row_s ex;
    bit chk;
    row_s rows[$] = '{
        '{23'h7C0000, 2'h0, 3'h0, 8'hFF, 3'h1, 3'h0, 5'h10},
        '{23'h7FFFFF, 2'h0, 3'h0, 8'hFF, 3'h1, 3'h0, 5'h10},
        '{23'h7BFFFF, 2'h1, 3'h7, 8'hFF, 3'h0, 3'h0, 5'h01},
        '{23'h7FFF00, 2'h0, 3'h0, 8'hFF, 3'h1, 3'h1, 5'h10},
        '{23'h7FFF07, 2'h0, 3'h0, 8'hFF, 3'h1, 3'h1, 5'h10},
        '{23'h7FFF0B, 2'h0, 3'h0, 8'hFF, 3'h1, 3'h2, 5'h10},
        '{23'h7FFF0C, 2'h0, 3'h0, 8'hFF, 3'h1, 3'h3, 5'h10},
        '{23'h7FFF0D, 2'h0, 3'h0, 8'hFF, 3'h1, 3'h4, 5'h10},
        '{23'h7FFF0E, 2'h0, 3'h0, 8'hFF, 3'h1, 3'h5, 5'h10},
        '{23'h7FFF0F, 2'h0, 3'h0, 8'hFF, 3'h1, 3'h6, 5'h10},
        '{23'h400000, 2'h0, 3'h4, 8'hFF, 3'h2, 3'h0, 5'h10},
        '{23'h4000E9, 2'h0, 3'h4, 8'hFF, 3'h2, 3'h0, 5'h10},
        '{23'h40013F, 2'h1, 3'h4, 8'hFF, 3'h2, 3'h0, 5'h08},
        '{23'h400008, 2'h0, 3'h4, 8'hFF, 3'h0, 3'h0, 5'h01},
        '{23'h400140, 2'h1, 3'h4, 8'hFF, 3'h0, 3'h0, 5'h01},
        '{23'h400000, 2'h0, 3'h3, 8'hFF, 3'h0, 3'h0, 5'h01},
        '{23'h4000E8, 2'h0, 3'h4, 8'hFF, 3'h2, 3'h0, 5'h10},
        '{23'h4000E8, 2'h0, 3'h0, 8'hFF, 3'h0, 3'h0, 5'h01},
        '{23'h300000, 2'h0, 3'h7, 8'hFF, 3'h0, 3'h0, 5'h01},
        '{23'h7FFFFF, 2'h2, 3'h0, 8'h80, 3'h1, 3'h0, 5'h02},
        '{23'h100000, 2'h1, 3'h0, 8'hFF, 3'h3, 3'h0, 5'h08},
        '{23'h101FFF, 2'h0, 3'h0, 8'hFF, 3'h3, 3'h0, 5'h10},
        '{23'h102000, 2'h1, 3'h0, 8'hFF, 3'h0, 3'h0, 5'h01},
        '{23'h120000, 2'h0, 3'h2, 8'hFF, 3'h4, 3'h0, 5'h10},
        '{23'h12007F, 2'h1, 3'h2, 8'hFF, 3'h4, 3'h0, 5'h08},
        '{23'h120080, 2'h0, 3'h2, 8'hFF, 3'h0, 3'h0, 5'h01},
        '{23'h12007F, 2'h1, 3'h5, 8'hFF, 3'h0, 3'h0, 5'h01},
        '{23'h123D00, 2'h0, 3'h1, 8'hFF, 3'h5, 3'h0, 5'h10},
        '{23'h123FFF, 2'h1, 3'h1, 8'hFF, 3'h5, 3'h0, 5'h08},
        '{23'h123CFF, 2'h0, 3'h1, 8'hFF, 3'h0, 3'h0, 5'h01},
        '{23'h123D00, 2'h1, 3'h6, 8'hFF, 3'h0, 3'h0, 5'h01},
        '{23'h7F8000, 2'h2, 3'h0, 8'h80, 3'h1, 3'h0, 5'h02},
        '{23'h7F8800, 2'h2, 3'h0, 8'h80, 3'h1, 3'h0, 5'h04},
        '{23'h7FF800, 2'h2, 3'h0, 8'h80, 3'h1, 3'h0, 5'h02},
        '{23'h7FF7FF, 2'h2, 3'h0, 8'h80, 3'h1, 3'h0, 5'h04},
        '{23'h7FBFFF, 2'h2, 3'h0, 8'h9B, 3'h1, 3'h0, 5'h02},
        '{23'h7F7FFF, 2'h2, 3'h0, 8'h9B, 3'h1, 3'h0, 5'h04},
        '{23'h7C0000, 2'h2, 3'h0, 8'h24, 3'h1, 3'h0, 5'h02},
        '{23'h7F8000, 2'h2, 3'h0, 8'h00, 3'h1, 3'h0, 5'h04},
        '{23'h7F8800, 2'h2, 3'h0, 8'h00, 3'h1, 3'h0, 5'h02},
        '{23'h7FFFFF, 2'h2, 3'h0, 8'hFF, 3'h1, 3'h0, 5'h04},
        '{23'h100000, 2'h2, 3'h0, 8'h00, 3'h3, 3'h0, 5'h04}
    };
    bus_master_model master (
        .addr_o(addr),
        .rd_o(rd),
        .wr_o(wr),
        .pe_o(pe)
    );
    flash_memory_map_decode uut (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .addr_i(addr),
        .rd_i(rd),
        .wr_i(wr),
        .pe_i(pe),
        .program_array_protection_i(prot),
        .program_info_row_visible_i(vis[2]),
        .data_info_row_visible_i(vis[1]),
        .scratch_ram_visible_i(vis[0]),
        .region_o(region_o),
        .cfg_field_o(cfg_field_o),
        .offset_o(offset_o),
        .rd_en_o(rd_en_o),
        .wr_en_o(wr_en_o),
        .pe_en_o(pe_en_o),
        .pe_blocked_o(pe_blocked_o),
        .unmapped_o(unmapped_o)
    );
    assign strobes = {rd_en_o, wr_en_o, pe_en_o, pe_blocked_o, unmapped_o};
    initial
    begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    function automatic logic [17:0] exp_off(input logic [2:0] rg, input logic [22:0] a);
        logic [22:0] b;
        case (rg)
            3'h1: b = flash_map_pkg::PFLASH_LO;
            3'h2: b = flash_map_pkg::PINFO_ID_LO;
            3'h3: b = flash_map_pkg::DFLASH_LO;
            3'h4: b = flash_map_pkg::DINFO_LO;
            3'h5: b = flash_map_pkg::SRAM_LO;
            default: b = a;
        endcase
        return 18'(a - b);
    endfunction
    // answer of the previous edge is settled by the falling edge
    always @(negedge ref_clk_i)
    begin
        if (chk)
        begin
            chk = 1'b0;
            `CHK("region", flash_map_pkg::region_e'(ex.rg), region_o)
            `CHK("cfg", flash_map_pkg::cfg_e'(ex.cf), cfg_field_o)
            `CHK("offset", exp_off(ex.rg, ex.a), offset_o)
            `CHK("strobes", ex.en, strobes)
        end
    end
    task automatic step(input row_s r, input bit hold);
        vis <= r.v;
        prot <= r.p;
        master.drive(r.k, r.a);
        @(posedge ref_clk_i);
        ex = r;
        chk = 1'b1;
        if (!hold)
        begin
            master.release_bus();
            @(posedge ref_clk_i);
        end
    endtask
    // a request under reset must leave every output quiet
    task automatic do_reset();
        rst_i <= 1'b1;
        step('{23'h7C0010, 2'h0, 3'h7, 8'hFF, 3'h0, 3'h0, 5'h00}, 1'b0);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        n_mismatch++;
        report_and_stop();
    end
    initial
    begin
        rst_i = 1'b1;
        vis = 3'h0;
        prot = 8'hFF;
        chk = 1'b0;
        n_mismatch = 0;
        tests_run = 0;
        repeat (4) @(posedge ref_clk_i);
        do_reset();
        foreach (rows[i])
            step(rows[i], 1'b0);
        // back-to-back phrase writes, reserved bytes refused
        for (int i = 0; i < 8; i++)
            step('{23'h7FFF08 + 23'(i), 2'h1, 3'h0, 8'hFF, 3'h1,
                (i < 4) ? 3'h2 : 3'(i - 1), (i < 4) ? 5'h00 : 5'h08}, i != 7);
        do_reset();
        step('{23'h7C0010, 2'h0, 3'h0, 8'hFF, 3'h1, 3'h0, 5'h10}, 1'b0);
        report_and_stop();
    end
endmodule // flash_memory_map_decode_bench
